//--- channel_model.sv
// Behavioural block multiplexer channel facing the disk control unit
`timescale 1ns/1ps
`default_nettype none

module channel_model (
    input  wire logic       core_clk_i,   // System clock
    input  wire logic       rst_n_i,      // Async reset, low
    input  wire logic       busy_hold_i,  // Bench keeps channel busy
    input  wire logic [3:0] ack_delay_i,  // Cycles before taking a request
    input  wire logic       reconn_req_i, // Unit asks to reconnect
    output logic            chan_busy_o,  // Channel busy level
    output logic            reconn_ack_o  // Reconnect taken, one cycle
);
    logic [3:0] wait_q; // Cycles the request has stood

    // Free unless another program holds it, so new seeks may start meanwhile
    assign chan_busy_o = busy_hold_i;

    // Take a standing request after the set delay; one pulse per request
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q       <= 4'h0;
            reconn_ack_o <= 1'b0;
        end else if (reconn_req_i && !busy_hold_i && !reconn_ack_o) begin
            // A request that drops restarts the count, no credit kept
            wait_q       <= wait_q + 4'h1;
            reconn_ack_o <= (wait_q >= ack_delay_i);
        end else begin
            wait_q       <= 4'h0;
            reconn_ack_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- disk_sector_reconnect_control.sv
// Disconnect and reconnect control for a multi-drive disk control unit
`timescale 1ns/1ps
`default_nettype none
`include "sector_reconnect_params.svh"

// How it works
// - Set sector stores target, watches drive
// - Accepting sector target disconnects unit
// - Read sector returns last record's sector
// - Sector arrival requests reconnection, resumes chain
// - Busy channel: retry every later pass
// - Position disk disconnects on moving seek
// - Arm arrival signals device end, reconnect
// - Plain disk shared: never disconnects
// - Plain disk nonshared: disconnect after chained seek
// - Tape on shared holds channel busy
// - Buffered devices disconnect during motion
// - Split ending nonshared capable unit disconnects if chained
// - Shared subchannel device never disconnects
// - Drives run concurrent programs, overlapped waits
// - Sector counter ticks, index clears it
// - Sector period 130 us, 128 sectors
module disk_sector_reconnect_control #(
    parameter int DRIVES       = `NUM_DRIVES,    // Drives on the unit
    parameter int SECTORS      = `SECTORS_PER_TRACK, // Sectors per track
    parameter int SECTOR_TICKS = `SECTOR_CYCLES  // Clocks per sector period
) (
    input  wire logic                           core_clk_i,     // System clock
    input  wire logic                           rst_n_i,        // Async reset, low
    input  wire logic                           cmd_valid_i,    // Command offered
    input  wire sector_reconnect_pkg::cmd_type  cmd_i,          // Command fields
    input  wire logic [1:0]                     dev_class_i,    // Device class
    input  wire logic                           shared_sub_i,   // Shared subchannel
    input  wire logic                           split_end_i,    // Channel end before device end
    input  wire logic                           disc_capable_i, // Unit can disconnect
    input  wire logic                           motion_i,       // Buffered mechanism moving
    input  wire logic [DRIVES-1:0]              arm_done_i,     // Arm reached cylinder
    input  wire logic [DRIVES-1:0]              index_i,        // Index mark per drive
    input  wire logic                           chan_busy_i,    // Channel busy
    input  wire logic                           reconn_ack_i,   // Channel took reconnect
    output logic                                cmd_ready_o,    // Command accepted
    output logic                                disconnect_o,   // Disconnect pulse
    output logic                                connected_o,    // Unit holds channel
    output logic                                reconn_req_o,   // Reconnect request
    output logic [2:0]                          reconn_drive_o, // Drive reconnecting
    output logic                                device_end_o,   // Device end pulse
    output logic [6:0]                          sector_data_o,  // Read sector answer
    output logic                                sector_valid_o  // Answer valid pulse
);
    localparam int SW = $clog2(SECTORS);

    // Sizes the ports cannot carry are refused
    if (DRIVES < 1 || DRIVES > 8) begin : gen_bad_drives
        $error("DRIVES must be 1..8");
    end
    if (SECTORS > 128) begin : gen_bad_sectors
        $error("SECTORS must fit 7 bits");
    end
    if (SECTOR_TICKS < 1) begin : gen_bad_ticks
        $error("SECTOR_TICKS must be positive");
    end

    // Sector period divider shared by all drives
    logic [$clog2(SECTOR_TICKS+1)-1:0] div_q; // Cycles into period
    logic [$clog2(SECTOR_TICKS+1)-1:0] div_d; // Next divider
    logic                              tick;  // One-cycle sector pulse

    always_comb begin
        tick  = (div_q == ($bits(div_q))'(SECTOR_TICKS - 1));
        div_d = tick ? '0 : div_q + 1'b1;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) div_q <= '0;
        else          div_q <= div_d;
    end

    // Per-drive counters and state
    logic [SW-1:0]                     cur_sec [DRIVES];  // Sector under heads
    logic [DRIVES-1:0]                 adv;               // Counter stepped
    sector_reconnect_pkg::drv_state_type st_q [DRIVES];   // Drive wait state
    sector_reconnect_pkg::drv_state_type st_d [DRIVES];   // Next state
    logic [SW-1:0]                     tgt_q [DRIVES];    // Pending target
    logic [SW-1:0]                     tgt_d [DRIVES];    // Next target
    logic [SW-1:0]                     last_q [DRIVES];   // Last record sector
    logic [SW-1:0]                     last_d [DRIVES];   // Next last sector
    logic [DRIVES-1:0]                 want;              // Drive wants channel
    logic [DRIVES-1:0]                 grant;             // Drive granted
    logic                              accept;            // Command taken
    logic                              take;              // Reconnect done this edge

    // Channel may send a command whenever it is not busy, even with a reconnect pending
    assign accept = cmd_valid_i && cmd_ready_o;
    assign take   = reconn_req_o && reconn_ack_i && !accept; // Command wins the edge

    // Reconnect requests pick the lowest drive asking
    always_comb begin
        grant = '0;
        for (int i = 0; i < DRIVES; i++) begin
            if (want[i] && grant == '0) grant[i] = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < DRIVES; g++) begin : gen_drive
            drive_sector_counter #(
                .SECTORS   (SECTORS)
            ) u_cnt (
                .core_clk_i(core_clk_i),
                .rst_n_i   (rst_n_i),
                .tick_i    (tick),
                .index_i   (index_i[g]),
                .sector_o  (cur_sec[g]),
                .advance_o (adv[g])
            );

            logic sel;   // Command targets this drive
            logic sec_q; // Pending wait is for a sector
            logic sec_d; // Next sector flag
            assign sel = accept && (cmd_i.drive == 3'(g));
            assign want[g] = (st_q[g] == sector_reconnect_pkg::DRV_RECONNECT);

            // Drive wait sequencing
            always_comb begin
                st_d[g]   = st_q[g];
                sec_d     = sec_q;
                tgt_d[g]  = tgt_q[g];
                last_d[g] = last_q[g];
                case (st_q[g])
                    sector_reconnect_pkg::DRV_IDLE: begin
                        if (sel && cmd_i.code == `CMD_SET_SECTOR) begin
                            tgt_d[g] = cmd_i.sector[SW-1:0];
                            st_d[g]  = sector_reconnect_pkg::DRV_SECTOR_WAIT;
                            sec_d    = 1'b1;
                        end else if (sel && cmd_i.code == `CMD_SEEK && cmd_i.arm_moves) begin
                            st_d[g] = sector_reconnect_pkg::DRV_SEEKING;
                            sec_d   = 1'b0;
                        end else if (sel && (cmd_i.code == `CMD_READ
                                || cmd_i.code == `CMD_WRITE || cmd_i.code == `CMD_SEARCH)) begin
                            last_d[g] = cur_sec[g];
                        end
                    end
                    sector_reconnect_pkg::DRV_SEEKING: begin
                        if (arm_done_i[g]) st_d[g] = sector_reconnect_pkg::DRV_RECONNECT;
                    end
                    sector_reconnect_pkg::DRV_SECTOR_WAIT: begin
                        // Compare only on a step: one attempt per pass
                        if (adv[g] && cur_sec[g] == tgt_q[g]) begin
                            st_d[g] = sector_reconnect_pkg::DRV_RECONNECT;
                        end
                    end
                    sector_reconnect_pkg::DRV_RECONNECT: begin
                        if (grant[g] && take) begin
                            st_d[g] = sector_reconnect_pkg::DRV_IDLE;
                        end else if (sec_q && chan_busy_i && tgt_q[g] != cur_sec[g]) begin
                            // Missed the window: wait for next revolution
                            st_d[g] = sector_reconnect_pkg::DRV_SECTOR_WAIT;
                        end
                    end
                    default: st_d[g] = sector_reconnect_pkg::DRV_IDLE;
                endcase
            end

            // Register drive state
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    st_q[g]   <= sector_reconnect_pkg::DRV_IDLE;
                    tgt_q[g]  <= '0;
                    last_q[g] <= '0;
                    sec_q     <= 1'b0;
                end else begin
                    st_q[g]   <= st_d[g];
                    tgt_q[g]  <= tgt_d[g];
                    last_q[g] <= last_d[g];
                    sec_q     <= sec_d;
                end
            end

            AST_RETRY_PASS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
                (st_q[g] == sector_reconnect_pkg::DRV_SECTOR_WAIT && adv[g]
                 && cur_sec[g] == tgt_q[g]) |=> want[g])
                else $error("sector pass did not raise reconnect");
        end
    endgenerate

    // Whether the current command lets the unit drop off the channel
    logic disc_ok; // Disconnection allowed for this command
    always_comb begin
        disc_ok = 1'b0;
        case (dev_class_i)
            `CLASS_DISK_RPS:   disc_ok = !shared_sub_i && (cmd_i.code == `CMD_SET_SECTOR
                                 || (cmd_i.code == `CMD_SEEK && cmd_i.arm_moves));
            `CLASS_DISK_PLAIN: disc_ok = !shared_sub_i && cmd_i.chained
                                 && cmd_i.code == `CMD_SEEK;
            `CLASS_TAPE:       disc_ok = 1'b0;
            `CLASS_BUFFERED:   disc_ok = !shared_sub_i && motion_i;
            default:           disc_ok = 1'b0;
        endcase
        // Other devices ending early may drop off if nonshared
        if (split_end_i && disc_capable_i && !shared_sub_i && cmd_i.chained) begin
            disc_ok = 1'b1;
        end
        if (shared_sub_i) disc_ok = 1'b0;
    end

    // Connection and answer registers
    logic       conn_q;   // Unit holds channel
    logic       conn_d;   // Next hold
    logic       disc_q;   // Disconnect pulse
    logic       disc_d;   // Next pulse
    logic       dend_q;   // Device end pulse
    logic       dend_d;   // Next pulse
    logic [6:0] sdat_q;   // Sector answer
    logic [6:0] sdat_d;   // Next answer
    logic       sval_q;   // Answer valid
    logic       sval_d;   // Next valid
    logic [2:0] rdrv;     // Granted drive index

    always_comb begin
        rdrv = '0;
        for (int i = 0; i < DRIVES; i++) begin
            if (grant[i]) rdrv = 3'(i);
        end
    end

    // Busy channel blocks reconnect; channel free to issue otherwise
    assign cmd_ready_o    = !chan_busy_i;
    assign reconn_req_o   = (|want) && !chan_busy_i;
    assign reconn_drive_o = rdrv;

    // Connection bookkeeping
    always_comb begin
        conn_d = conn_q;
        disc_d = 1'b0;
        dend_d = 1'b0;
        sval_d = 1'b0;
        sdat_d = sdat_q;
        if (accept) begin
            conn_d = !disc_ok;
            disc_d = disc_ok;
            if (cmd_i.code == `CMD_READ_SECTOR) begin
                sdat_d = 7'(last_q[cmd_i.drive]);
                sval_d = 1'b1;
            end
        end else if (take) begin
            conn_d = 1'b1;
            dend_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conn_q <= 1'b0;
            disc_q <= 1'b0;
            dend_q <= 1'b0;
            sdat_q <= 7'h00;
            sval_q <= 1'b0;
        end else begin
            conn_q <= conn_d;
            disc_q <= disc_d;
            dend_q <= dend_d;
            sdat_q <= sdat_d;
            sval_q <= sval_d;
        end
    end

    assign connected_o    = conn_q;
    assign disconnect_o   = disc_q;
    assign device_end_o   = dend_q;
    assign sector_data_o  = sdat_q;
    assign sector_valid_o = sval_q;

    AST_SHARED_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (accept && shared_sub_i) |=> !disconnect_o)
        else $error("shared subchannel disconnected");
    AST_TAPE_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (accept && dev_class_i == `CLASS_TAPE && !split_end_i) |=> connected_o)
        else $error("tape released channel");
    AST_SET_SECTOR_DISC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (accept && !shared_sub_i && dev_class_i == `CLASS_DISK_RPS
         && cmd_i.code == `CMD_SET_SECTOR) |=> (disconnect_o && !connected_o))
        else $error("set sector did not disconnect");
    AST_PLAIN_SHARED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (accept && shared_sub_i && dev_class_i == `CLASS_DISK_PLAIN) |=> connected_o)
        else $error("plain disk on shared released");
    AST_PLAIN_NONSHARED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (accept && !shared_sub_i && dev_class_i == `CLASS_DISK_PLAIN && cmd_i.chained
         && cmd_i.code == `CMD_SEEK) |=> disconnect_o)
        else $error("plain disk nonshared stayed");
    AST_BUFFER_DISC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (accept && !shared_sub_i && dev_class_i == `CLASS_BUFFERED && motion_i)
        |=> disconnect_o)
        else $error("buffered device stayed during motion");
    AST_RECONN_DEVEND: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (reconn_req_o && reconn_ack_i && !accept) |=> (device_end_o && connected_o))
        else $error("reconnect without device end");
    AST_NO_REQ_BUSY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        chan_busy_i |-> !reconn_req_o)
        else $error("reconnect raised while channel busy");
endmodule
`default_nettype wire

//--- disk_sector_reconnect_control_tb.sv
// Self-checking bench for the disk sector reconnect control block
`timescale 1ns/1ps
`default_nettype none
`include "sector_reconnect_params.svh"

module disk_sector_reconnect_control_tb;
    localparam int TICKS = 4;                  // Short sector period: 512 clocks a turn
    localparam int SECS  = `SECTORS_PER_TRACK; // Sectors per track

    logic                          core_clk_i, rst_n_i, cmd_valid_i;   // Clock, reset, offer
    sector_reconnect_pkg::cmd_type cmd_i;                               // Command fields
    logic [1:0]                    dev_class_i;                         // Device class
    logic                          shared_sub_i, split_end_i;           // Subchannel, status
    logic                          disc_capable_i, motion_i;            // Unit abilities
    logic [7:0]                    arm_done_i, index_i;                 // Per drive pulses
    logic                          chan_busy_i, reconn_ack_i;           // From channel
    logic                          busy_hold;                           // Busy request
    logic [3:0]                    ack_delay;                           // Channel answer delay
    logic                          cmd_ready_o, disconnect_o, connected_o; // Unit status
    logic                          reconn_req_o, device_end_o, sector_valid_o;
    logic [2:0]                    reconn_drive_o;                      // Reconnecting drive
    logic [6:0]                    sector_data_o;                       // Sector report
    logic [31:0]                   lfsr_q, r;                           // Random source
    logic [2:0]                    code;                                // Random command
    logic [1:0]                    cl;                                  // Random class
    logic                          sh, sp, ch;                          // Random flags
    int                            n_errors, n_checks, t0, want_sec, cyc = 0;
    logic [2:0] pick [5] = '{`CMD_SEEK, `CMD_READ, `CMD_WRITE, `CMD_SEARCH, `CMD_OTHER};
    logic [2:0] recs [3] = '{`CMD_READ, `CMD_WRITE, `CMD_SEARCH};

    disk_sector_reconnect_control #(.SECTOR_TICKS(TICKS)) uut (.core_clk_i, .rst_n_i,
        .cmd_valid_i, .cmd_i, .dev_class_i, .shared_sub_i, .split_end_i, .disc_capable_i,
        .motion_i, .arm_done_i, .index_i, .chan_busy_i, .reconn_ack_i, .cmd_ready_o,
        .disconnect_o, .connected_o, .reconn_req_o, .reconn_drive_o, .device_end_o,
        .sector_data_o, .sector_valid_o);

    channel_model chan (.core_clk_i, .rst_n_i, .busy_hold_i(busy_hold),
        .ack_delay_i(ack_delay), .reconn_req_i(reconn_req_o), .chan_busy_o(chan_busy_i),
        .reconn_ack_o(reconn_ack_i));

    // Free running clock and cycle stamp
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) cyc <= cyc + 1;

    // Shift register with feedback, fixed start keeps runs repeatable
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Expected disconnect for one accepted command
    function automatic logic exp_disc(input logic [2:0] c, input logic [1:0] k,
                                      input logic s, p, a, m, h, v);
        if (s) return 1'b0;
        if (c == `CMD_SET_SECTOR && k == `CLASS_DISK_RPS) return 1'b1;
        if (c == `CMD_SEEK && k == `CLASS_DISK_RPS) return v;
        if (c == `CMD_SEEK && k == `CLASS_DISK_PLAIN) return h;
        if (k == `CLASS_BUFFERED) return m;
        return p && a && h;
    endfunction

    // One comparison; mismatches reported at once
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // Offer a command until taken, then check the unit's answer a cycle later
    task automatic issue(input logic [2:0] c, d, input logic [6:0] s, input logic [1:0] k,
                         input logic sb, p, a, m, h, v);
        logic e;
        int   n;
        e = exp_disc(c, k, sb, p, a, m, h, v);
        cmd_i          <= sector_reconnect_pkg::cmd_type'{c, d, s, h, v};
        dev_class_i    <= k;
        shared_sub_i   <= sb;
        split_end_i    <= p;
        disc_capable_i <= a;
        motion_i       <= m;
        cmd_valid_i    <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (cmd_ready_o !== 1'b1 && n < 100);
        cmd_valid_i <= 1'b0;
        @(negedge core_clk_i);
        chk(disconnect_o === e, "disconnect after accept");
        chk(connected_o === !e, "connection level after accept");
        if (c == `CMD_READ_SECTOR) begin
            // Counter phase is free, so one sector either way is allowed
            chk(sector_valid_o === 1'b1, "sector report strobe");
            chk((sector_data_o - want_sec[6:0]) inside {7'h00, 7'h01, 7'h7F}, "sector value");
        end
        @(posedge core_clk_i);
    endtask

    // Single cycle pulse on index or arm done lines
    task automatic pulse(input logic arm, input logic [7:0] m);
        if (arm) arm_done_i <= m;
        else index_i <= m;
        @(posedge core_clk_i);
        arm_done_i <= 8'h00;
        index_i    <= 8'h00;
    endtask

    // Await a reconnect request inside a window, then device end once taken
    task automatic wait_req(input logic [2:0] d, input int t, lo, hi);
        int n;
        do @(negedge core_clk_i); while (reconn_req_o !== 1'b1 && cyc - t < hi);
        chk(cyc - t >= lo && cyc - t <= hi, "reconnect request timing");
        chk(reconn_drive_o === d, "reconnecting drive");
        n = 0;
        while (device_end_o !== 1'b1 && n < 12) begin
            @(negedge core_clk_i);
            n++;
        end
        chk(device_end_o === 1'b1, "device end after reconnect");
        chk(connected_o === 1'b1, "connected after reconnect");
        @(posedge core_clk_i);
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well past the roughly 1500 cycles the tests need
    initial begin
        repeat (30000) @(posedge core_clk_i);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end

    // Main sequence
    initial begin
        {rst_n_i, cmd_valid_i, split_end_i, disc_capable_i, motion_i, busy_hold} = '0;
        {shared_sub_i, dev_class_i, arm_done_i, index_i, ack_delay} = '0;
        cmd_i    = '0;
        lfsr_q   = 32'h0001_0746;
        n_errors = 0;
        n_checks = 0;
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        // Two sector waits and a seek overlapped on one unit
        pulse(1'b0, 8'h24);
        t0 = cyc;
        issue(`CMD_SET_SECTOR, 3'h5, 7'h1E, `CLASS_DISK_RPS, 0, 0, 1, 0, 1, 0);
        issue(`CMD_SET_SECTOR, 3'h2, 7'h2D, `CLASS_DISK_RPS, 0, 0, 1, 0, 1, 0);
        issue(`CMD_SEEK, 3'h6, 7'h00, `CLASS_DISK_RPS, 0, 0, 1, 0, 1, 1);
        pulse(1'b1, 8'h40);
        wait_req(3'h6, cyc, 0, 8);
        wait_req(3'h5, t0, TICKS * 30 - 6, TICKS * 30 + 8);
        wait_req(3'h2, t0, TICKS * 45 - 6, TICKS * 45 + 8);
        // Busy channel across sector arrival: retry one turn later, slow answer
        ack_delay <= 4'h3;
        pulse(1'b0, 8'h02);
        t0 = cyc;
        issue(`CMD_SET_SECTOR, 3'h1, 7'h0C, `CLASS_DISK_RPS, 0, 0, 1, 0, 1, 0);
        while (cyc - t0 < TICKS * 12 - 10) @(posedge core_clk_i);
        busy_hold <= 1'b1;
        while (cyc - t0 < TICKS * 12 + 16) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk(cmd_ready_o === 1'b0 && reconn_req_o === 1'b0, "busy channel refused");
        @(posedge core_clk_i);
        busy_hold <= 1'b0;
        wait_req(3'h1, t0, TICKS * (SECS + 12) - 6, TICKS * (SECS + 12) + 8);
        // Sector report after each record command kind
        ack_delay <= 4'h0;
        for (int i = 0; i < 3; i++) begin
            pulse(1'b0, 8'h08);
            t0 = cyc;
            want_sec = 10 + 7 * i;
            while (cyc - t0 < TICKS * want_sec) @(posedge core_clk_i);
            issue(recs[i], 3'h3, 7'h00, `CLASS_DISK_RPS, 0, 0, 1, 0, 1, 0);
            issue(`CMD_READ_SECTOR, 3'h3, 7'h00, `CLASS_DISK_RPS, 0, 0, 1, 0, 1, 0);
        end
        // Hand-picked subchannel corner cases
        issue(`CMD_SEEK, 3'h0, 7'h00, `CLASS_DISK_PLAIN, 1, 0, 1, 0, 1, 1);
        issue(`CMD_OTHER, 3'h4, 7'h00, `CLASS_TAPE, 1, 1, 1, 0, 1, 0);
        issue(`CMD_OTHER, 3'h4, 7'h00, `CLASS_DISK_PLAIN, 0, 1, 1, 0, 1, 0);
        issue(`CMD_OTHER, 3'h4, 7'h00, `CLASS_DISK_PLAIN, 0, 1, 0, 0, 1, 0);
        // Random mix; tape kept shared, split status only on plain disks
        for (int i = 0; i < 60; i++) begin
            repeat (21) lfsr_q = lfsr_next(lfsr_q);
            r    = lfsr_q;
            code = pick[r[2:0] % 5];
            cl   = r[4:3];
            sh   = (cl == `CLASS_TAPE) || (cl == `CLASS_DISK_PLAIN && r[5]);
            sp   = (cl == `CLASS_DISK_PLAIN && code != `CMD_SEEK) && r[6];
            ch   = (code == `CMD_SEEK) || r[19];
            issue(code, r[9:7], r[16:10], cl, sh, sp, r[17], r[18], ch, r[20]);
            motion_i <= 1'b0;
            if (code == `CMD_SEEK) pulse(1'b1, 8'h01 << r[9:7]);
            repeat (6) @(posedge core_clk_i);
        end
        summarize();
    end
endmodule
`default_nettype wire

//--- drive_sector_counter.sv
// Per-drive rotational sector counter
`timescale 1ns/1ps
`default_nettype none
`include "sector_reconnect_params.svh"

module drive_sector_counter #(
    parameter int SECTORS = `SECTORS_PER_TRACK // Sectors on a track
) (
    input  wire logic                       core_clk_i,  // System clock
    input  wire logic                       rst_n_i,     // Async reset, low
    input  wire logic                       tick_i,      // Sector period pulse
    input  wire logic                       index_i,     // Index mark pulse
    output logic [$clog2(SECTORS)-1:0]      sector_o,    // Current sector
    output logic                            advance_o    // Counter moved
);
    localparam int W = $clog2(SECTORS);

    if (SECTORS < 2) begin : gen_bad_sectors
        $error("SECTORS must be at least 2");
    end

    logic [W-1:0] count_q; // Sector under the heads
    logic [W-1:0] count_d; // Next sector
    logic         adv_q;   // Counter advanced last cycle
    logic         adv_d;   // Next advance flag

    // Index wins over tick so the track origin never drifts
    always_comb begin
        count_d = count_q;
        adv_d   = 1'b0;
        if (index_i) begin
            count_d = '0;
            adv_d   = 1'b1;
        end else if (tick_i) begin
            count_d = (count_q == W'(SECTORS - 1)) ? '0 : count_q + 1'b1;
            adv_d   = 1'b1;
        end
    end

    // Register the counter
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= '0;
            adv_q   <= 1'b0;
        end else begin
            count_q <= count_d;
            adv_q   <= adv_d;
        end
    end

    assign sector_o  = count_q;
    assign advance_o = adv_q;

    AST_INDEX_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        index_i |=> (count_q == '0))
        else $error("sector counter not cleared by index");
endmodule
`default_nettype wire

//--- sector_reconnect_params.svh
// Constants for the disk sector reconnect control block
`ifndef SECTOR_RECONNECT_PARAMS_SVH
`define SECTOR_RECONNECT_PARAMS_SVH

// Sector geometry and timing
`define SECTORS_PER_TRACK   128
`define SECTOR_TIME_NS      130000
`define CLK_PERIOD_NS       10
`define SECTOR_CYCLES       ((`SECTOR_TIME_NS) / (`CLK_PERIOD_NS))
`define NUM_DRIVES          8

// Command codes on the command port
`define CMD_SEEK            3'h1
`define CMD_SET_SECTOR      3'h2
`define CMD_READ_SECTOR     3'h3
`define CMD_READ            3'h4
`define CMD_WRITE           3'h5
`define CMD_SEARCH          3'h6
`define CMD_OTHER           3'h7

// Device classes
`define CLASS_DISK_RPS      2'h0
`define CLASS_DISK_PLAIN    2'h1
`define CLASS_TAPE          2'h2
`define CLASS_BUFFERED      2'h3

`endif

//--- sector_reconnect_pkg.sv
// Types shared by the sector reconnect control block
package sector_reconnect_pkg;
    // One command from the channel
    typedef struct packed {
        logic [2:0] code;      // Command code
        logic [2:0] drive;     // Target drive
        logic [6:0] sector;    // Sector number argument
        logic       chained;   // Command chaining flag
        logic       arm_moves; // Seek actually moves the arm
    } cmd_type;

    // Per-drive wait state
    typedef enum logic [1:0] {
        DRV_IDLE,
        DRV_SEEKING,
        DRV_SECTOR_WAIT,
        DRV_RECONNECT
    } drv_state_type;
endpackage
